// ---- rtl/psic_bank.sv ----
// per-source interrupt control registers with apb access and arbitration
//
// How it works
// - one control register is kept for every maskable source.
// - each register is written as a byte over apb or one bit at a time through the bit operation register.
// - reset leaves every register at 47h: flag clear, mask set, level 7.
// - bit 7 is the request flag, bit 6 the mask, bits 5 to 3 read zero, bits 2 to 0 the level.
// - the registers sit one per printed halfword offset from 110h to 15ah.
// - eight levels are arbitrated and the lower source number wins a tie.
// - requests stay pending while masked or while the core is busy in service.
// - each mask bit is also reached through grouped mask registers sharing the same storage.
`timescale 1ns/100ps
`default_nettype none
module psic_bank #(
    parameter int N = psic_pkg::SRC_N
) (
    input  wire logic                          clk,         // 125 mhz clock
    input  wire logic                          sys_rst,     // sync reset, high
    input  wire logic                          psel,        // apb select
    input  wire logic                          penable,     // apb access phase
    input  wire logic                          pwrite,      // apb write
    input  wire logic [psic_pkg::ADDR_W-1:0]   paddr,       // apb byte address
    input  wire logic [31:0]                   pwdata,      // apb write data
    input  wire logic [3:0]                    pstrb,       // apb byte strobes
    output logic                               pready,      // apb ready
    output logic [31:0]                        prdata,      // apb read data
    output logic                               pslverr,     // apb error
    input  wire logic [N-1:0]                  src_req,     // source request pulses
    input  wire logic                          cpu_busy,    // core in service or globally off
    input  wire logic                          cpu_ack,     // core takes the grant
    output logic                               irq_req,     // request to core
    output psic_pkg::psic_grant_t              irq_grant,   // granted source and level
    output logic                               irq          // block event interrupt
);
    logic [N-1:0]        flag_r;
    logic [N-1:0]        flag_nxt;
    logic [N-1:0]        mask_r;
    logic [N-1:0]        mask_nxt;
    logic [2:0]          prio_r [N];
    logic [2:0]          prio_nxt [N];
    logic [31:0]         prdata_r;
    logic [psic_pkg::ST_W-1:0] stat_r;
    logic [psic_pkg::ST_W-1:0] imask_r;
    psic_pkg::psic_grant_t     grant_r;

    // apb phase decode
    wire       setup_ph = psel && !penable;
    wire       acc_ph   = psel && penable;
    wire       wr_acc   = acc_ph && pwrite;
    wire [9:0] reg_idx  = paddr[11:2];
    wire [9:0] rel_idx  = reg_idx - psic_pkg::CTRL_FIRST_IDX;

    // control registers sit on even halfword offsets only
    // address decode
    wire ctrl_hit = (paddr[1:0] == 2'h0) && (reg_idx >= psic_pkg::CTRL_FIRST_IDX)
                    && (reg_idx <= psic_pkg::CTRL_LAST_IDX) && !rel_idx[0];
    wire [psic_pkg::IDX_W-1:0] ctrl_sel = rel_idx[psic_pkg::IDX_W:1];
    wire bitop_hit  = paddr == psic_pkg::BITOP_ADDR;
    wire gm0_hit    = paddr == psic_pkg::GMASK0_ADDR;
    wire gm1_hit    = paddr == psic_pkg::GMASK1_ADDR;
    wire stat_hit   = paddr == psic_pkg::STAT_ADDR;
    wire imask_hit  = paddr == psic_pkg::IMASK_ADDR;
    wire arb_hit    = paddr == psic_pkg::ARB_ADDR;
    wire any_hit    = ctrl_hit || bitop_hit || gm0_hit || gm1_hit || stat_hit || imask_hit || arb_hit;

    // the slave never stalls, unmapped accesses error
    assign pready  = 1'b1;
    assign pslverr = acc_ph && !any_hit;
    assign prdata  = prdata_r;

    // bit operation word fields
    wire [psic_pkg::IDX_W-1:0] bo_idx = pwdata[psic_pkg::BITOP_IDX_LSB +: psic_pkg::IDX_W];
    wire [2:0]                 bo_bit = pwdata[psic_pkg::BITOP_BIT_LSB +: 3];
    wire psic_pkg::psic_op_t   bo_op  = psic_pkg::psic_op_t'(pwdata[psic_pkg::BITOP_OP_LSB +: 2]);
    // fixed-zero bits and unknown ops cannot be operated on
    wire bo_ok = (bo_idx < N) && !(bo_bit inside {3'h3, 3'h4, 3'h5}) && (bo_op != psic_pkg::PSIC_OP_RSV);
    wire bo_wr = wr_acc && bitop_hit && pstrb[1:0] == 2'h3;

    // byte image of the addressed register for the bit operation
    wire [7:0] bo_cur = (bo_idx < N) ? {flag_r[bo_idx], mask_r[bo_idx], 3'h0, prio_r[bo_idx]} : 8'h00;
    wire [7:0] bo_one = 8'h01 << bo_bit;
    wire [7:0] bo_new = (bo_op == psic_pkg::PSIC_OP_SET) ? (bo_cur | bo_one) :
                        (bo_op == psic_pkg::PSIC_OP_CLR) ? (bo_cur & ~bo_one) : (bo_cur ^ bo_one);

    // one register update per access, byte write or bit operation
    // byte or bit access
    wire                       upd_en   = (wr_acc && ctrl_hit && pstrb[0]) || (bo_wr && bo_ok);
    wire [psic_pkg::IDX_W-1:0] upd_idx  = ctrl_hit ? ctrl_sel : bo_idx;
    wire [7:0]                 upd_byte = ctrl_hit ? pwdata[7:0] : bo_new;
    wire                       gm0_wr   = wr_acc && gm0_hit;
    wire                       gm1_wr   = wr_acc && gm1_hit;

    // grouped mask write data spread over the source index
    logic [63:0] gm_data;
    logic [63:0] gm_en;
    always_comb begin
        gm_data = {pwdata, pwdata};
        gm_en   = 64'h0;
        for (int b = 0; b < 4; b++) begin
            gm_en[b*8 +: 8]      = {8{gm0_wr && pstrb[b]}};
            gm_en[32 + b*8 +: 8] = {8{gm1_wr && pstrb[b]}};
        end
    end

    // acknowledge clears the source that was granted
    wire ack_take = cpu_ack && grant_r.valid;

    // next value of every control register
    always_comb begin
        for (int i = 0; i < N; i++) begin
            flag_nxt[i] = flag_r[i];
            mask_nxt[i] = mask_r[i];
            prio_nxt[i] = prio_r[i];
            if (upd_en && upd_idx == i[psic_pkg::IDX_W-1:0]) begin
                flag_nxt[i] = upd_byte[psic_pkg::FLAG_BIT];
                mask_nxt[i] = upd_byte[psic_pkg::MASK_BIT];
                prio_nxt[i] = upd_byte[2:0];
            end
            if (gm_en[i])
                mask_nxt[i] = gm_data[i];
            if (ack_take && grant_r.id == i[psic_pkg::IDX_W-1:0])
                flag_nxt[i] = 1'b0;
            // request sets flag, a set beats any clear
            if (src_req[i])
                flag_nxt[i] = 1'b1;
        end
    end

    // storage for all sources
    // one register each
    always_ff @(posedge clk) begin
        for (int i = 0; i < N; i++) begin
            flag_r[i] <= sys_rst ? psic_pkg::CTRL_RESET[psic_pkg::FLAG_BIT] : flag_nxt[i];
            mask_r[i] <= sys_rst ? psic_pkg::CTRL_RESET[psic_pkg::MASK_BIT] : mask_nxt[i];
            prio_r[i] <= sys_rst ? psic_pkg::PRIO_RESET : prio_nxt[i];
        end
    end

    // arbitration: lowest level code first, then lowest source number
    logic                       win_valid;
    logic [psic_pkg::IDX_W-1:0] win_id;
    logic [2:0]                 win_lvl;
    always_comb begin
        win_valid = 1'b0;
        win_id    = '0;
        win_lvl   = psic_pkg::PRIO_RESET;
        for (int i = 0; i < N; i++) begin
            if (flag_r[i] && !mask_r[i] && (!win_valid || prio_r[i] < win_lvl)) begin
                win_valid = 1'b1;
                win_id    = i[psic_pkg::IDX_W-1:0];
                win_lvl   = prio_r[i];
            end
        end
    end

    // grant is registered; an ack that arrives this cycle clears it next
    always_ff @(posedge clk) begin
        if (sys_rst || ack_take)
            grant_r <= '0;
        else
            grant_r <= '{valid: win_valid, id: win_id, level: win_lvl};
    end

    assign irq_req   = grant_r.valid && !cpu_busy;
    assign irq_grant = grant_r;

    // block events: grant taken, bad bit operation or unmapped access
    wire [psic_pkg::ST_W-1:0] ev = {(bo_wr && !bo_ok) || pslverr, ack_take};
    wire [psic_pkg::ST_W-1:0] st_clr = (wr_acc && stat_hit && pstrb[0]) ? pwdata[psic_pkg::ST_W-1:0] : '0;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stat_r  <= '0;
            imask_r <= '0;
        end else begin
            // write one clears, a new event wins
            stat_r <= (stat_r & ~st_clr) | ev;
            if (wr_acc && imask_hit && pstrb[0])
                imask_r <= pwdata[psic_pkg::ST_W-1:0];
        end
    end
    assign irq = |(stat_r & imask_r);

    // read mux, sampled in the setup cycle so prdata is a flop in the access phase
    // fixed zero bits
    wire [31:0] ctrl_rd = {24'h0, flag_r[ctrl_sel], mask_r[ctrl_sel], 3'h0, prio_r[ctrl_sel]};
    wire [63:0] gm_rd   = {{(64-N){1'b1}}, mask_r};
    wire [31:0] rd_mux  = ctrl_hit  ? ctrl_rd :
                          gm0_hit   ? gm_rd[31:0] :
                          gm1_hit   ? gm_rd[63:32] :
                          stat_hit  ? {30'h0, stat_r} :
                          imask_hit ? {30'h0, imask_r} :
                          arb_hit   ? {22'h0, grant_r.valid, win_valid, grant_r.id, 2'h0} : 32'h0;
    always_ff @(posedge clk) begin
        if (sys_rst)
            prdata_r <= 32'h0;
        else if (setup_ph && !pwrite)
            prdata_r <= rd_mux;
    end

    // helpers for the checks below
    logic better_exists;
    always_comb begin
        better_exists = 1'b0;
        for (int i = 0; i < N; i++)
            if (flag_r[i] && !mask_r[i] && (prio_r[i] < win_lvl || (prio_r[i] == win_lvl && i < win_id)))
                better_exists = 1'b1;
    end
    wire [psic_pkg::ADDR_W-1:0] last_addr = {psic_pkg::SRC_OFS[N-1][9:0], 2'h0};

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_reset_value: assert property ($past(sys_rst) |-> !flag_r[0] && mask_r[N-1] && prio_r[0] == 3'h7)
        else $error("control register not at reset value");
    a_byte_write: assert property (wr_acc && ctrl_hit && pstrb[0] && ctrl_sel == 0 |=> prio_r[0] == $past(pwdata[2:0]))
        else $error("byte write lost");
    a_zero_bits: assert property (acc_ph && !pwrite && $past(setup_ph && ctrl_hit) |-> prdata[31:8] == 24'h0 && prdata[5:3] == 3'h0)
        else $error("fixed bits not zero");
    a_req_sets: assert property (src_req[0] |=> flag_r[0] ##1 (flag_r[0] || $past(ack_take)))
        else $error("request not latched");
    a_ack_clears: assert property (ack_take && !src_req[grant_r.id] |=> !flag_r[$past(grant_r.id)] && !grant_r.valid)
        else $error("ack did not clear flag");
    a_mask_blocks: assert property (win_valid |-> !mask_r[win_id] && flag_r[win_id])
        else $error("masked source won");
    a_prio_order: assert property (win_valid |-> !better_exists)
        else $error("arbitration order broken");
    a_busy_holds: assert property (cpu_busy |-> !irq_req)
        else $error("request passed while busy");
    a_mask_mirror: assert property (gm0_wr && pstrb[0] && !upd_en |=> mask_r[0] == $past(pwdata[0]))
        else $error("grouped mask not shared");
    a_last_decode: assert property (acc_ph && paddr == last_addr |-> !pslverr && ctrl_sel == N-1)
        else $error("last register not decoded");
endmodule
`default_nettype wire

// ---- rtl/psic_pkg.sv ----
// shared constants and types for the per-source interrupt control bank
package psic_pkg;
    localparam int SRC_N   = 38;
    localparam int IDX_W   = 6;
    localparam int PRIO_W  = 3;
    localparam int ADDR_W  = 12;

    // printed register offsets, one per source, in default order
    localparam logic [31:0] SRC_OFS [SRC_N] = '{
        32'hfffff110, 32'hfffff112, 32'hfffff114, 32'hfffff116, 32'hfffff118, 32'hfffff11a,
        32'hfffff11c, 32'hfffff11e, 32'hfffff120, 32'hfffff122, 32'hfffff124, 32'hfffff126,
        32'hfffff128, 32'hfffff12a, 32'hfffff12c, 32'hfffff12e, 32'hfffff130, 32'hfffff132,
        32'hfffff134, 32'hfffff136, 32'hfffff138, 32'hfffff13a, 32'hfffff13c, 32'hfffff13e,
        32'hfffff140, 32'hfffff142, 32'hfffff144, 32'hfffff146, 32'hfffff148, 32'hfffff14a,
        32'hfffff14c, 32'hfffff14e, 32'hfffff150, 32'hfffff152, 32'hfffff154, 32'hfffff156,
        32'hfffff158, 32'hfffff15a};
    // register index is the low ten bits of the printed offset
    localparam logic [9:0] CTRL_FIRST_IDX = 10'h110;
    localparam logic [9:0] CTRL_LAST_IDX  = 10'h15a;

    // control register layout and reset value
    localparam int         FLAG_BIT   = 7;
    localparam int         MASK_BIT   = 6;
    localparam logic [7:0] CTRL_RESET = 8'h47;
    localparam logic [2:0] PRIO_RESET = 3'h7;

    // block-level registers
    localparam logic [ADDR_W-1:0] BITOP_ADDR  = 12'h800;
    localparam logic [ADDR_W-1:0] GMASK0_ADDR = 12'h804;
    localparam logic [ADDR_W-1:0] GMASK1_ADDR = 12'h808;
    localparam logic [ADDR_W-1:0] STAT_ADDR   = 12'h80c;
    localparam logic [ADDR_W-1:0] IMASK_ADDR  = 12'h810;
    localparam logic [ADDR_W-1:0] ARB_ADDR    = 12'h814;

    // bit operation word fields
    localparam int BITOP_IDX_LSB = 0;
    localparam int BITOP_BIT_LSB = 6;
    localparam int BITOP_OP_LSB  = 9;

    // block status bits
    localparam int ST_ACK = 0;
    localparam int ST_ERR = 1;
    localparam int ST_W   = 2;

    typedef enum logic [1:0] {PSIC_OP_CLR, PSIC_OP_SET, PSIC_OP_NOT, PSIC_OP_RSV} psic_op_t;

    typedef struct packed {
        logic              valid;
        logic [IDX_W-1:0]  id;
        logic [PRIO_W-1:0] level;
    } psic_grant_t;
endpackage

// ---- bench/psic_core_model.sv ----
// core model: takes each grant after a set delay
`timescale 1ns/100ps
`default_nettype none
module psic_core_model (
    input  wire logic                  clk,       // clock
    input  wire logic                  sys_rst,   // sync reset
    input  wire logic                  hold,      // interrupts globally off
    input  wire logic [3:0]            dly,       // cycles before ack
    input  wire logic                  irq_req,   // request from bank
    input  wire psic_pkg::psic_grant_t irq_grant, // granted source
    output logic                       cpu_busy,  // busy to bank
    output logic                       cpu_ack,   // ack pulse
    output logic [5:0]                 ack_id,    // last acked source
    output logic [7:0]                 ack_cnt    // acks taken
);
    logic [3:0] cnt_r;
    assign cpu_busy = hold;
    // one pulse then a gap, so a stale grant is never taken twice
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cpu_ack <= 1'b0;
            cnt_r   <= 4'h0;
            ack_id  <= 6'h00;
            ack_cnt <= 8'h00;
        end else if (cpu_ack) begin
            cpu_ack <= 1'b0;
            cnt_r   <= 4'h0;
        end else if (irq_req && cnt_r >= dly) begin
            cpu_ack <= 1'b1;
            ack_id  <= irq_grant.id;
            ack_cnt <= ack_cnt + 8'h01;
        end else begin
            cnt_r <= irq_req ? cnt_r + 4'h1 : 4'h0;
        end
    end
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
// self-checking bench for the per-source interrupt control bank
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, cpu_busy, cpu_ack, irq_req, irq, hold, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed;
    logic [3:0]  pstrb, dly;
    logic [37:0] src_req;
    logic [5:0]  ack_id;
    logic [7:0]  ack_cnt, c, d, x;
    logic [2:0]  la, lb;
    psic_pkg::psic_grant_t irq_grant;
    int n_fail = 0;
    int n_tests = 0;
    int k, a, b, i;

    psic_bank DUT (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .src_req(src_req), .cpu_busy(cpu_busy), .cpu_ack(cpu_ack), .irq_req(irq_req),
        .irq_grant(irq_grant), .irq(irq));
    psic_core_model core (.clk(clk), .sys_rst(sys_rst), .hold(hold), .dly(dly), .irq_req(irq_req),
        .irq_grant(irq_grant), .cpu_busy(cpu_busy), .cpu_ack(cpu_ack), .ack_id(ack_id), .ack_cnt(ack_cnt));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task test_done;
        if (n_fail == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] xp, input logic [31:0] g);
        n_tests++;
        if (g !== xp) begin
            n_fail++;
            $display("[FAIL] %s exp %h got %h", nm, xp, g);
        end
    endtask

    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // byte address of a control register: printed low bits times four
    function logic [11:0] ra(input int n);
        return {psic_pkg::SRC_OFS[n][9:0], 2'b00};
    endfunction

    // level code first, lower source number on a tie
    function int win(input int p, input logic [2:0] lp, input int q, input logic [2:0] lq);
        if (lp != lq) return (lp < lq) ? p : q;
        return (p < q) ? p : q;
    endfunction

    // one apb transfer; read data and error land in rd and e
    task apb(input logic w, input logic [11:0] ad, input logic [31:0] wd, input logic [3:0] s);
        int t;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task waitack(input logic [7:0] c0);
        int t;
        t = 0;
        while (ack_cnt === c0 && t < 100) begin
            @(posedge clk);
            t++;
        end
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        test_done;
    end

    initial begin
        seed = 32'h0000821c;
        sys_rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata, pstrb, src_req, dly} = '0;
        hold = 1'b1;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        // every control register comes out of reset at its documented value
        for (k = 0; k < 38; k++) begin
            apb(1'b0, ra(k), 32'h0, 4'h0);
            chk("ctrl reset", 32'h47, rd);
            chk("pready", 32'h1, {31'h0, pready});
        end
        // random byte writes; the zero field must stay zero
        for (k = 0; k < 38; k++) begin
            d = rnd() & 8'h7f;
            apb(1'b1, ra(k), {24'h0, d}, 4'h1);
            apb(1'b0, ra(k), 32'h0, 4'h0);
            chk("ctrl byte", {24'h0, d & 8'h47}, rd);
        end
        // single-bit clear, set, invert and a refused op on the mask bit
        for (i = 0; i < 4; i++) begin
            k = rnd() % 38;
            apb(1'b0, ra(k), 32'h0, 4'h0);
            d = rd[7:0];
            x = (i == 0) ? d & 8'hbf : (i == 1) ? d | 8'h40 : (i == 2) ? d ^ 8'h40 : d;
            apb(1'b1, psic_pkg::BITOP_ADDR, {21'h0, i[1:0], 3'd6, k[5:0]}, 4'h3);
            apb(1'b0, ra(k), 32'h0, 4'h0);
            chk("bit op", {24'h0, x}, rd);
        end
        // refused op and an unmapped hole raise the error event
        apb(1'b0, ra(0) + 12'h004, 32'h0, 4'h0);
        chk("slverr", 32'h1, {31'h0, e});
        apb(1'b1, psic_pkg::IMASK_ADDR, 32'h2, 4'h1);
        @(negedge clk);
        chk("irq raised", 32'h1, {31'h0, irq});
        apb(1'b1, psic_pkg::STAT_ADDR, 32'h2, 4'h1);
        @(negedge clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        // masked request stays pending, flag visible with interrupts off
        k = 5;
        apb(1'b1, ra(k), 32'h43, 4'h1);
        src_req[k] <= 1'b1;
        @(posedge clk);
        src_req <= '0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("masked valid", 32'h0, {31'h0, irq_grant.valid});
        apb(1'b0, ra(k), 32'h0, 4'h0);
        chk("flag set", 32'hc3, rd);
        apb(1'b0, psic_pkg::GMASK0_ADDR, 32'h0, 4'h0);
        apb(1'b1, psic_pkg::GMASK0_ADDR, rd & ~(32'h1 << k), 4'hf);
        apb(1'b0, ra(k), 32'h0, 4'h0);
        chk("shared mask", 32'h83, rd);
        @(negedge clk);
        chk("busy hold", 32'h0, {31'h0, irq_req});
        chk("held id", k, {26'h0, irq_grant.id});
        apb(1'b0, psic_pkg::ARB_ADDR, 32'h0, 4'h0);
        chk("arb view", 32'h300 | (k << 2), rd);
        c = ack_cnt;
        @(posedge clk);
        hold <= 1'b0;
        waitack(c);
        chk("acked id", k, {26'h0, ack_id});
        hold <= 1'b1;
        apb(1'b0, ra(k), 32'h0, 4'h0);
        chk("flag cleared", 32'h03, rd);
        apb(1'b0, psic_pkg::STAT_ADDR, 32'h0, 4'h0);
        chk("ack status", 32'h1, rd & 32'h1);
        // random pairs raised together, first four on one level
        for (i = 0; i < 12; i++) begin
            a = rnd() % 38;
            b = (a + 1 + rnd() % 37) % 38;
            la = rnd();
            lb = (i < 4) ? la : rnd();
            dly <= rnd();
            apb(1'b1, ra(a), {29'h0, la}, 4'h1);
            apb(1'b1, ra(b), {29'h0, lb}, 4'h1);
            @(posedge clk);
            src_req[a] <= 1'b1;
            src_req[b] <= 1'b1;
            @(posedge clk);
            src_req <= '0;
            repeat (3) @(posedge clk);
            @(negedge clk);
            chk("winner id", win(a, la, b, lb), {26'h0, irq_grant.id});
            chk("winner level", (win(a, la, b, lb) == a) ? la : lb, {29'h0, irq_grant.level});
            c = ack_cnt;
            @(posedge clk);
            hold <= 1'b0;
            waitack(c);
            chk("first acked", win(a, la, b, lb), {26'h0, ack_id});
            waitack(c + 8'h01);
            chk("second acked", (win(a, la, b, lb) == a) ? b : a, {26'h0, ack_id});
            hold <= 1'b1;
        end
        test_done;
    end
endmodule
`default_nettype wire
